// File: design/ewcs_consts.svh
/*
 * Timing counts and sizes for the bit-serial EEPROM host controller.
 * Assumes a 100 MHz system clock; every count except EWCS_SYNC_CYC is derived from a time in ns or us.
 */
`ifndef EWCS_CONSTS_SVH
`define EWCS_CONSTS_SVH

`define EWCS_CLK_NS        10
`define EWCS_T_WES_NS      25
`define EWCS_T_LOW_NS      50
`define EWCS_T_HIGH_NS     50
`define EWCS_T_ACC_NS      25
`define EWCS_SYNC_CYC      3
`define EWCS_WES_CYC       ((`EWCS_T_WES_NS + `EWCS_CLK_NS - 1) / `EWCS_CLK_NS)
`define EWCS_WLOW_CYC      ((`EWCS_T_LOW_NS + `EWCS_CLK_NS - 1) / `EWCS_CLK_NS)
`define EWCS_HIGH_CYC      ((`EWCS_T_HIGH_NS + `EWCS_CLK_NS - 1) / `EWCS_CLK_NS)
`define EWCS_ACC_CYC       ((`EWCS_T_ACC_NS + `EWCS_CLK_NS - 1) / `EWCS_CLK_NS)
`define EWCS_RLOW_CYC      (`EWCS_ACC_CYC + `EWCS_SYNC_CYC + 1)
`define EWCS_NV_TMO_US     10000
`define EWCS_NV_TMO_CYC    (`EWCS_NV_TMO_US * 1000 / `EWCS_CLK_NS)
`define EWCS_PAGE_BYTES    64
`define EWCS_ADDR_BITS     16
`define EWCS_BYTE_BITS     8

`endif

// File: design/ewcs_cyc_if.sv
/*
 * Link between the sequencer and the single bus cycle engine.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface ewcs_cyc_if;
    logic req;
    logic wr;
    logic wbit;
    logic ready;
    logic done;
    logic rbit;
    logic io_lvl;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic io_o;
    logic io_oe;

    modport seq (output req, wr, wbit, io_lvl,
                 input  ready, done, rbit, ce_n, oe_n, we_n, io_o, io_oe);
    modport eng (input  req, wr, wbit, io_lvl,
                 output ready, done, rbit, ce_n, oe_n, we_n, io_o, io_oe);
endinterface
`default_nettype wire

// File: design/ewcs_cycle.sv
/*
 * Runs one bus read or write cycle on the select, enable and data pins.
 * Assumes the data level arrives already synchronised on io_lvl.
 */
`include "ewcs_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module ewcs_cycle
    import ewcs_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    ewcs_cyc_if.eng   cyc
);
    ewcs_eng_t  st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic       ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
    logic       io_q, io_d, io_oe_q, io_oe_d, rbit_q, rbit_d, done_q, done_d, wr_q, wr_d;
    wire        cnt_zero = (cnt_q == 4'h0);

    assign cyc.ready = (st_q == E_IDLE);
    assign cyc.done  = done_q;
    assign cyc.rbit  = rbit_q;
    assign cyc.ce_n  = ce_n_q;
    assign cyc.oe_n  = oe_n_q;
    assign cyc.we_n  = we_n_q;
    assign cyc.io_o  = io_q;
    assign cyc.io_oe = io_oe_q;

    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_zero ? cnt_q : cnt_q - 4'h1;
        ce_n_d  = ce_n_q;
        oe_n_d  = oe_n_q;
        we_n_d  = we_n_q;
        io_d    = io_q;
        io_oe_d = io_oe_q;
        rbit_d  = rbit_q;
        wr_d    = wr_q;
        done_d  = 1'b0;
        unique case (st_q)
            E_IDLE: begin
                if (cyc.req) begin
                    wr_d    = cyc.wr;
                    io_d    = cyc.wbit;
                    io_oe_d = cyc.wr;
                    we_n_d  = !cyc.wr;
                    oe_n_d  = cyc.wr;
                    cnt_d   = 4'(`EWCS_WES_CYC - 1);
                    st_d    = E_SET;
                end
            end
            E_SET: begin
                if (cnt_zero) begin
                    ce_n_d = 1'b0;
                    cnt_d  = wr_q ? 4'(`EWCS_WLOW_CYC - 1) : 4'(`EWCS_RLOW_CYC - 1);
                    st_d   = E_LOW;
                end
            end
            E_LOW: begin
                if (cnt_zero) begin
                    // Select and write enable rise together so the device latches the bit.
                    ce_n_d = 1'b1;
                    we_n_d = 1'b1;
                    oe_n_d = 1'b1;
                    rbit_d = wr_q ? rbit_q : cyc.io_lvl;
                    cnt_d  = 4'(`EWCS_HIGH_CYC - 1);
                    st_d   = E_HIGH;
                end
            end
            E_HIGH: begin
                if (cnt_zero) begin
                    io_oe_d = 1'b0;
                    done_d  = 1'b1;
                    st_d    = E_IDLE;
                end
            end
            default: st_d = E_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= E_IDLE;
            cnt_q <= 4'h0;
            {ce_n_q, oe_n_q, we_n_q} <= 3'h7;
            {io_q, io_oe_q, rbit_q, done_q, wr_q} <= 5'h00;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            {ce_n_q, oe_n_q, we_n_q} <= {ce_n_d, oe_n_d, we_n_d};
            {io_q, io_oe_q, rbit_q, done_q, wr_q} <= {io_d, io_oe_d, rbit_d, done_d, wr_d};
        end
    end
endmodule
`default_nettype wire

// File: design/ewcs_host.sv
/*
 * Host controller for a bit-serial EEPROM on a memory-style bus: reset,
 * addressed read, page write with commit and status polling.
 * Assumes the device pins are wired directly and the data pin is resolved outside.
 */
`include "ewcs_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module ewcs_host
    import ewcs_pkg::*;
#(
    parameter int unsigned P_NV_TIMEOUT_CYC = `EWCS_NV_TMO_CYC
) (
    input  wire logic       I_SYS_CLK,
    input  wire logic       I_RST_N,
    input  wire logic       I_CMD_VALID,
    output logic            O_CMD_READY,
    input  wire ewcs_cmd_t  I_CMD,
    input  wire logic [15:0] I_ADDR,
    input  wire logic [6:0] I_LEN,
    input  wire logic       I_WR_VALID,
    output logic            O_WR_READY,
    input  wire logic [7:0] I_WR_DATA,
    output logic            O_RD_VALID,
    output logic [7:0]      O_RD_DATA,
    output logic            O_BUSY,
    output logic            O_DONE,
    output logic            O_NV_DONE,
    output logic            O_TIMEOUT,
    output logic            O_CE_N,
    output logic            O_OE_N,
    output logic            O_WE_N,
    output logic            O_WP_N,
    output logic            O_IO,
    output logic            O_IO_OE,
    input  wire logic       I_IO
);
    logic        rst_s1_q, rst_n_q;
    logic        io_s1_q, io_s2_q, io_s3_q, io_lvl_q;
    ewcs_seq_t   st_q, st_d;
    ewcs_cmd_t   op_q, op_d;
    logic [15:0] sh_q, sh_d;
    logic [3:0]  bit_q, bit_d;
    logic [6:0]  byte_q, byte_d;
    logic [31:0] tmr_q, tmr_d;
    logic        pend_q, pend_d, have_q, have_d, single_q, single_d;
    logic        rdv_q, rdv_d, done_q, done_d, nvok_q, nvok_d, tmo_q, tmo_d, wp_q;
    logic [7:0]  rdd_q, rdd_d;
    ewcs_cyc_if  cyc ();

    // Reset release and three-stage data pin synchroniser.
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            {rst_s1_q, rst_n_q} <= 2'h0;
        end else begin
            {rst_s1_q, rst_n_q} <= {1'b1, rst_s1_q};
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            {io_s1_q, io_s2_q, io_s3_q, io_lvl_q} <= 4'hF;
        end else begin
            {io_s1_q, io_s2_q, io_s3_q} <= {I_IO, io_s1_q, io_s2_q};
            io_lvl_q <= (io_s2_q == io_s3_q) ? io_s3_q : io_lvl_q;
        end
    end

    ewcs_cycle u_cycle (
        .i_clk   (I_SYS_CLK),
        .i_rst_n (rst_n_q),
        .cyc     (cyc.eng)
    );

    wire is_wr_st   = (st_q == S_RST1) || (st_q == S_ADDR) || (st_q == S_DATA) ||
                      (st_q == S_STBY) || (st_q == S_CM1);
    wire active     = (st_q != S_IDLE) && (st_q != S_DONE);
    wire data_wait  = (st_q == S_DATA) && !have_q;
    wire issue      = active && !pend_q && !data_wait;
    wire accept     = issue && cyc.ready;
    wire bit_zero   = (bit_q == 4'h0);
    wire last_byte  = (byte_q == 7'h01);
    wire tmo_hit    = (tmr_q >= P_NV_TIMEOUT_CYC);
    wire [6:0] len1 = (I_LEN == 7'h00) ? 7'h01 : I_LEN;
    // Host never loads more than one page, so the device counter never wraps over data.
    wire [6:0] wlen = (len1 > 7'(`EWCS_PAGE_BYTES)) ? 7'(`EWCS_PAGE_BYTES) : len1;
    // Reset cycle carries zero; standby and commit writes carry one.
    wire wbit_sel   = (st_q == S_RST1) ? 1'b0 :
                      ((st_q == S_ADDR) || (st_q == S_DATA)) ? sh_q[15] : 1'b1;

    assign cyc.req     = issue;
    assign cyc.wr      = is_wr_st;
    assign cyc.wbit    = wbit_sel;
    assign cyc.io_lvl  = io_lvl_q;
    assign O_CMD_READY = (st_q == S_IDLE);
    assign O_WR_READY  = data_wait;
    assign O_BUSY      = (st_q != S_IDLE);
    assign O_RD_VALID  = rdv_q;
    assign O_RD_DATA   = rdd_q;
    assign O_DONE      = done_q;
    assign O_NV_DONE   = nvok_q;
    assign O_TIMEOUT   = tmo_q;
    assign O_CE_N      = cyc.ce_n;
    assign O_OE_N      = cyc.oe_n;
    assign O_WE_N      = cyc.we_n;
    assign O_IO        = cyc.io_o;
    assign O_IO_OE     = cyc.io_oe;
    assign O_WP_N      = wp_q;

    always_comb begin
        st_d     = st_q;
        op_d     = op_q;
        sh_d     = sh_q;
        bit_d    = bit_q;
        byte_d   = byte_q;
        tmr_d    = (st_q == S_POLL) ? tmr_q + 32'h0000_0001 : 32'h0000_0000;
        pend_d   = accept ? 1'b1 : (cyc.done ? 1'b0 : pend_q);
        have_d   = have_q;
        single_d = single_q;
        rdv_d    = 1'b0;
        rdd_d    = rdd_q;
        done_d   = 1'b0;
        nvok_d   = nvok_q;
        tmo_d    = tmo_q;
        if (data_wait && I_WR_VALID) begin
            sh_d[15:8] = I_WR_DATA;
            have_d     = 1'b1;
        end
        unique case (st_q)
            S_IDLE: begin
                if (I_CMD_VALID) begin
                    op_d     = I_CMD;
                    sh_d     = I_ADDR;
                    byte_d   = (I_CMD == CMD_WRITE) ? wlen : len1;
                    single_d = (I_CMD == CMD_POLL);
                    nvok_d   = 1'b0;
                    tmo_d    = 1'b0;
                    // A lone status poll needs no reset and is valid at any time.
                    st_d     = (I_CMD == CMD_POLL) ? S_POLL : S_RST0;
                end
            end
            S_RST0: if (cyc.done) st_d = S_RST1;
            S_RST1: if (cyc.done) st_d = S_RST2;
            S_RST2: begin
                if (cyc.done) begin
                    // Every read or write opens with the reset sequence.
                    bit_d = 4'(`EWCS_ADDR_BITS - 1);
                    st_d  = (op_q == CMD_RESET) ? S_DONE : S_ADDR;
                end
            end
            S_ADDR: begin
                if (cyc.done) begin
                    // Address bits go MSB first with no read in between.
                    sh_d  = {sh_q[14:0], 1'b0};
                    bit_d = bit_q - 4'h1;
                    if (bit_zero) begin
                        bit_d  = 4'(`EWCS_BYTE_BITS - 1);
                        have_d = 1'b0;
                        st_d   = (op_q == CMD_WRITE) ? S_DATA : S_RDAT;
                    end
                end
            end
            S_DATA: begin
                if (cyc.done) begin
                    // Only whole bytes are sent before the commit; stalls keep select high.
                    sh_d  = {sh_q[14:0], 1'b0};
                    bit_d = bit_q - 4'h1;
                    if (bit_zero) begin
                        bit_d  = 4'(`EWCS_BYTE_BITS - 1);
                        have_d = 1'b0;
                        byte_d = byte_q - 7'h01;
                        st_d   = last_byte ? S_CM0 : S_DATA;
                    end
                end
            end
            S_RDAT: begin
                if (cyc.done) begin
                    // Reads continue straight into the next byte while the device stays active.
                    sh_d  = {sh_q[14:0], cyc.rbit};
                    bit_d = bit_q - 4'h1;
                    if (bit_zero) begin
                        bit_d  = 4'(`EWCS_BYTE_BITS - 1);
                        rdd_d  = {sh_q[6:0], cyc.rbit};
                        rdv_d  = 1'b1;
                        byte_d = byte_q - 7'h01;
                        st_d   = last_byte ? S_STBY : S_RDAT;
                    end
                end
            end
            S_STBY: if (cyc.done) st_d = S_DONE;
            S_CM0:  if (cyc.done) st_d = S_CM1;
            S_CM1:  if (cyc.done) st_d = S_CM2;
            S_CM2:  if (cyc.done) st_d = S_POLL;
            S_POLL: begin
                if (cyc.done) begin
                    // Data line low means busy, high means the write is over.
                    nvok_d = cyc.rbit;
                    if (cyc.rbit || single_q) begin
                        st_d = S_DONE;
                    end else if (tmo_hit) begin
                        tmo_d = 1'b1;
                        st_d  = S_DONE;
                    end
                end
            end
            S_DONE: begin
                done_d = 1'b1;
                st_d   = S_IDLE;
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge I_SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= S_IDLE;
            op_q <= CMD_RESET;
            sh_q <= 16'h0000;
            {bit_q, byte_q} <= 11'h000;
            tmr_q <= 32'h0000_0000;
            {pend_q, have_q, single_q, rdv_q, done_q, nvok_q, tmo_q} <= 7'h00;
            rdd_q <= 8'h00;
            wp_q <= 1'b0;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            sh_q <= sh_d;
            {bit_q, byte_q} <= {bit_d, byte_d};
            tmr_q <= tmr_d;
            {pend_q, have_q, single_q, rdv_q, done_q, nvok_q, tmo_q} <=
                {pend_d, have_d, single_d, rdv_d, done_d, nvok_d, tmo_d};
            rdd_q <= rdd_d;
            // Protect stays low except during a page write.
            wp_q <= (op_d == CMD_WRITE) && (st_d != S_IDLE);
        end
    end
endmodule
`default_nettype wire

// File: design/ewcs_pkg.sv
/*
 * Types shared by the EEPROM host controller modules.
 * Assumes nothing of its surroundings.
 */
package ewcs_pkg;

    typedef enum logic [1:0] {
        CMD_RESET = 2'h0,
        CMD_READ  = 2'h1,
        CMD_WRITE = 2'h2,
        CMD_POLL  = 2'h3
    } ewcs_cmd_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_RST0 = 4'h1,
        S_RST1 = 4'h3,
        S_RST2 = 4'h2,
        S_ADDR = 4'h6,
        S_DATA = 4'h7,
        S_CM0  = 4'h5,
        S_CM1  = 4'h4,
        S_CM2  = 4'hC,
        S_POLL = 4'hD,
        S_DONE = 4'hF,
        S_RDAT = 4'hE,
        S_STBY = 4'hA
    } ewcs_seq_t;

    typedef enum logic [1:0] {
        E_IDLE = 2'h0,
        E_SET  = 2'h1,
        E_LOW  = 2'h3,
        E_HIGH = 2'h2
    } ewcs_eng_t;

endpackage

// File: verif/ewcs_dev_model.sv
/*
 * Behavioural bit-serial EEPROM answering the host pins.
 * Assumes the host strobes are registered on the bench clock.
 */
`timescale 1ns/1ns
`default_nettype none
module ewcs_dev_model (
    input  wire logic        i_clk,
    input  wire logic        i_ce_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic        i_wp_n,
    input  wire logic        i_host_io,
    input  wire logic        i_host_oe,
    input  wire logic [31:0] i_nv_cyc,
    output logic             o_io,
    output int               o_nv_starts
);
    logic [7:0]  mem [65536];
    logic [7:0]  pbuf [64];
    logic [63:0] pmask = '0;
    logic [15:0] addr = '0;
    logic        latch = 1'b0, rd = 1'b0, prev_rd = 1'b0, b, last_lvl = 1'b0;
    int          mode = 0, bits = 0, lbits = 0, busy = 0;
    initial begin
        o_nv_starts = 0;
        foreach (mem[i]) mem[i] = 8'hff;
    end
    // A released pin shows the inverse of its last level.
    assign o_io = i_host_oe ? i_host_io : (!i_ce_n && !i_oe_n) ?
        (busy > 0 ? 1'b0 : mode == 4 ? mem[addr][7 - bits] : 1'b1) : ~last_lvl;
    always @(posedge i_clk) begin
        last_lvl <= o_io;
        if (busy == 1) latch = 1'b0;
        if (busy > 0) busy = busy - 1;
    end
    always @(negedge i_ce_n) begin
        rd = !i_oe_n;
        if (rd && mode == 2) begin
            mode = 4;
            bits = 0;
        end
    end
    always @(posedge i_ce_n) begin
        b = i_host_io;
        if (!rd) begin
            if (prev_rd && !b && mode != 1) begin
                mode = 7;
                if (busy == 0) latch = 1'b1;
            end else if (prev_rd && b && mode != 1) begin
                if (mode == 5) mode = 6;
                else begin
                    latch = 1'b0;
                    mode = 0;
                end
            end else if (mode == 1) begin
                addr = {addr[14:0], b};
                bits++;
                if (bits == 16) mode = 2;
            end else if (mode == 2 || mode == 3) begin
                if (mode == 2) lbits = 0;
                if (mode == 2) pmask = '0;
                mode = 3;
                pbuf[6'(addr[5:0] + lbits / 8)][7 - lbits % 8] = b;
                pmask[6'(addr[5:0] + lbits / 8)] = 1'b1;
                lbits++;
            end
        end else begin
            case (mode)
                7: begin
                    mode = 1;
                    bits = 0;
                end
                1, 5: begin
                    latch = 1'b0;
                    mode = 0;
                end
                3: mode = 5;
                4: begin
                    bits++;
                    if (bits == 8) addr++;
                    if (bits == 8) bits = 0;
                end
                6: begin
                    mode = 0;
                    if (latch && i_wp_n && lbits % 8 == 0) begin
                        for (int i = 0; i < 64; i++) if (pmask[i]) mem[{addr[15:6], 6'(i)}] = pbuf[i];
                        busy = i_nv_cyc;
                        o_nv_starts++;
                    end else latch = 1'b0;
                end
                default: ;
            endcase
        end
        prev_rd = rd;
    end
endmodule
`default_nettype wire

// File: verif/ewcs_host_sva.sv
/*
 * Checker for the pin timing and status outputs of the EEPROM host.
 * Assumes it is bound to ewcs_host and sees only its ports.
 */
`timescale 1ns/1ns
`default_nettype none
module ewcs_host_chk (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire logic O_CMD_READY,
    input wire logic O_BUSY,
    input wire logic O_DONE,
    input wire logic O_NV_DONE,
    input wire logic O_TIMEOUT,
    input wire logic O_CE_N,
    input wire logic O_OE_N,
    input wire logic O_WE_N,
    input wire logic O_WP_N,
    input wire logic O_IO,
    input wire logic O_IO_OE
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);

    a_no_dual_enable: assert property (!O_CE_N |-> (O_OE_N || O_WE_N))
        else $error("write and output enable both low while selected");
    a_read_released: assert property (!O_OE_N |-> !O_IO_OE)
        else $error("host drives the data pin during a read");
    a_write_stable: assert property (!O_CE_N && !O_WE_N |-> O_IO_OE && $stable(O_IO))
        else $error("write data moves while selected");
    a_write_setup: assert property ($fell(O_CE_N) && !O_WE_N |-> !$past(O_WE_N, 2) && $past(O_IO_OE, 2))
        else $error("write data not set up before select");
    a_write_hold: assert property ($rose(O_CE_N) && !$past(O_WE_N) |-> (O_IO_OE && $stable(O_IO)) [*4])
        else $error("write data not held after select rises");
    a_read_length: assert property ($fell(O_CE_N) && !O_OE_N |-> !O_CE_N [*7] ##1 O_CE_N)
        else $error("read select low time wrong");
    a_write_length: assert property ($fell(O_CE_N) && !O_WE_N |-> !O_CE_N [*5] ##1 O_CE_N)
        else $error("write select low time wrong");
    a_protect_idle: assert property (O_WP_N |-> O_BUSY)
        else $error("write protect released outside a write");
    a_bus_free: assert property (O_CMD_READY |-> O_CE_N && O_OE_N && O_WE_N && !O_IO_OE)
        else $error("strobes active while idle");
    a_done_ready: assert property (O_DONE |-> O_CMD_READY ##1 !O_DONE)
        else $error("ready does not follow done");
    a_timeout_excl: assert property (O_TIMEOUT |-> !O_NV_DONE)
        else $error("timeout and write done together");
endmodule
bind ewcs_host ewcs_host_chk ewcs_host_chk_inst (.I_SYS_CLK, .I_RST_N, .O_CMD_READY, .O_BUSY, .O_DONE,
    .O_NV_DONE, .O_TIMEOUT, .O_CE_N, .O_OE_N, .O_WE_N, .O_WP_N, .O_IO, .O_IO_OE);
`default_nettype wire

// File: verif/ewcs_host_tb_top.sv
/*
 * Self-checking bench for the EEPROM host with a device model on its pins.
 * Assumes a 100 MHz clock and a shortened write poll limit.
 */
`timescale 1ns/1ns
`default_nettype none
module ewcs_host_tb_top
    import ewcs_pkg::*;
;
    logic        I_SYS_CLK = 1'b0, I_RST_N = 1'b0, I_CMD_VALID = 1'b0, I_WR_VALID = 1'b0;
    ewcs_cmd_t   I_CMD = CMD_RESET;
    logic [15:0] I_ADDR = 16'h0000, base;
    logic [6:0]  I_LEN = 7'h00, lens [3];
    logic [7:0]  I_WR_DATA = 8'h00, O_RD_DATA, wbuf [64], rbuf [64], shadow [65536];
    logic        O_CMD_READY, O_WR_READY, O_RD_VALID, O_BUSY, O_DONE, O_NV_DONE, O_TIMEOUT;
    logic        O_CE_N, O_OE_N, O_WE_N, O_WP_N, O_IO, O_IO_OE, pin_lvl;
    logic [31:0] nv_cyc = 32'h0000_012c;
    int          mismatches = 0, checks_done = 0, wcount, rcount, nv_starts;

    always #5 I_SYS_CLK = ~I_SYS_CLK;
    ewcs_host #(.P_NV_TIMEOUT_CYC(2000)) ewcs_host_inst (.I_SYS_CLK, .I_RST_N, .I_CMD_VALID, .O_CMD_READY,
        .I_CMD, .I_ADDR, .I_LEN, .I_WR_VALID, .O_WR_READY, .I_WR_DATA, .O_RD_VALID, .O_RD_DATA, .O_BUSY,
        .O_DONE, .O_NV_DONE, .O_TIMEOUT, .O_CE_N, .O_OE_N, .O_WE_N, .O_WP_N, .O_IO, .O_IO_OE, .I_IO(pin_lvl));
    ewcs_dev_model ewcs_dev_model_inst (.i_clk(I_SYS_CLK), .i_ce_n(O_CE_N), .i_oe_n(O_OE_N), .i_we_n(O_WE_N),
        .i_wp_n(O_WP_N), .i_host_io(O_IO), .i_host_oe(O_IO_OE), .i_nv_cyc(nv_cyc), .o_io(pin_lvl),
        .o_nv_starts(nv_starts));

    function automatic int exp_len(input logic [6:0] n);
        return (n == 0) ? 1 : (n > 64) ? 64 : int'(n);
    endfunction
    function automatic logic [15:0] wrap_adr(input logic [15:0] a, input int i);
        return {a[15:6], 6'(a[5:0] + i)};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Offers one command, feeds write bytes, gathers read bytes, waits for done.
    task automatic run_cmd(input ewcs_cmd_t c, input logic [15:0] a, input logic [6:0] n);
        int t;
        t = 0;
        while (O_CMD_READY !== 1'b1 && t < 100) begin
            @(negedge I_SYS_CLK);
            t++;
        end
        if (t >= 100) mismatches++;
        if (t >= 100) tally_and_finish();
        {I_CMD, I_ADDR, I_LEN, I_CMD_VALID} <= {c, a, n, 1'b1};
        wcount = 0;
        rcount = 0;
        @(negedge I_SYS_CLK);
        I_CMD_VALID <= 1'b0;
        t = 0;
        while (O_DONE !== 1'b1 && t < 40000) begin
            I_WR_VALID <= (O_WR_READY === 1'b1 && wcount < 64);
            if (O_WR_READY === 1'b1 && wcount < 64) I_WR_DATA <= wbuf[wcount++];
            if (O_RD_VALID === 1'b1 && rcount < 64) rbuf[rcount++] = O_RD_DATA;
            @(negedge I_SYS_CLK);
            t++;
        end
        I_WR_VALID <= 1'b0;
        if (t >= 40000) mismatches++;
        if (t >= 40000) tally_and_finish();
    endtask

    initial begin
        void'($urandom(32'h0000_b95d));
        foreach (shadow[i]) shadow[i] = 8'hff;
        repeat (6) @(negedge I_SYS_CLK);
        I_RST_N <= 1'b1;
        repeat (4) @(negedge I_SYS_CLK);
        check("ready", O_CMD_READY, 1);
        check("strobes", {O_CE_N, O_OE_N, O_WE_N, O_WP_N, O_IO_OE}, 5'b11100);
        lens = '{7'($urandom_range(64, 1)), 7'h08, 7'h46};
        for (int k = 0; k < 3; k++) begin
            base = 16'($urandom);
            if (k == 1) base[5:0] = 6'h3c;
            foreach (wbuf[i]) wbuf[i] = 8'($urandom);
            run_cmd(CMD_WRITE, base, lens[k]);
            check("nv_done", O_NV_DONE, 1);
            check("timeout", O_TIMEOUT, 0);
            check("wr_bytes", wcount, exp_len(lens[k]));
            check("nv_starts", nv_starts, k + 1);
            for (int i = 0; i < exp_len(lens[k]); i++) shadow[wrap_adr(base, i)] = wbuf[i];
            run_cmd(CMD_READ, {base[15:6], 6'h00}, 7'h40);
            check("rd_bytes", rcount, 64);
            for (int i = 0; i < 64; i++) check("rd_data", rbuf[i], shadow[{base[15:6], 6'(i)}]);
        end
        nv_cyc = 32'h0000_1388;
        run_cmd(CMD_WRITE, base, 7'h01);
        check("timeout", O_TIMEOUT, 1);
        check("nv_done", O_NV_DONE, 0);
        run_cmd(CMD_POLL, base, 7'h01);
        check("poll_busy", O_NV_DONE, 0);
        run_cmd(CMD_RESET, base, 7'h01);
        run_cmd(CMD_POLL, base, 7'h01);
        check("poll_after_reset", O_NV_DONE, 0);
        repeat (5000) @(negedge I_SYS_CLK);
        run_cmd(CMD_POLL, base, 7'h01);
        check("poll_done", O_NV_DONE, 1);
        check("nv_starts", nv_starts, 4);
        tally_and_finish();
    end
endmodule
`default_nettype wire
